// File: urpsc_timer.sv
package urpsc_pkg;
   // APB byte offsets
   localparam logic [7:0]  OFS_PORT_STATUS = 8'h00;
   localparam logic [7:0]  OFS_CONFIG      = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h0C;

   // Port status word bit positions
   localparam int          BIT_CONNECTED   = 0;
   localparam int          BIT_ENABLED     = 1;
   localparam int          BIT_SUSPENDED   = 2;
   localparam int          BIT_OVERCURRENT = 3;
   localparam int          BIT_RESET_ACT   = 4;
   localparam int          BIT_CONN_CHG    = 16;
   localparam int          BIT_EN_CHG      = 17;
   localparam int          BIT_RESUME_CHG  = 18;
   localparam int          BIT_RESET_CHG   = 20;

   // Config register bit positions
   localparam int          CFG_PER_PORT_OC = 0;
   localparam int          CFG_FIXED_ATT   = 1;
   localparam int          CFG_POWER       = 2;
   localparam logic [2:0]  CFG_RESET       = 3'h4;

   // Interrupt status / mask bit positions
   localparam int          IRQ_CONN_CHG    = 0;
   localparam int          IRQ_EN_CHG      = 1;
   localparam int          IRQ_RESUME_CHG  = 2;
   localparam int          IRQ_RESET_CHG   = 3;
   localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;

   // Signalling durations
   localparam int          CLK_MHZ         = 25;
   localparam int          RESET_TIME_US   = 10000;
   localparam int          RESUME_TIME_US  = 20000;
   localparam int          RESET_CYCLES    = RESET_TIME_US * CLK_MHZ;
   localparam int          RESUME_CYCLES   = RESUME_TIME_US * CLK_MHZ;
   localparam int          TMR_W           = 24;

   typedef enum logic [2:0] {
      URPSC_IDLE   = 3'b001,
      URPSC_RESET  = 3'b010,
      URPSC_RESUME = 3'b100
   } urpsc_state_t;
endpackage : urpsc_pkg

`timescale 1ns/100ps
`default_nettype none

module urpsc_timer
   import urpsc_pkg::*;
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Control
   input  wire logic             start,
   input  wire logic             abort,
   input  wire logic [TMR_W-1:0] load,
   // Status
   output logic                  busy,
   output logic                  done
);
   logic [TMR_W-1:0] cnt_ff;
   logic             busy_ff;
   logic             done_ff;
   wire              last = busy_ff && (cnt_ff == '0);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end
      else
      begin
         done_ff <= last && !abort;
         if (abort)
            busy_ff <= 1'b0;
         else if (start)
         begin
            busy_ff <= 1'b1;
            cnt_ff  <= load - 1'b1;
         end
         else if (last)
            busy_ff <= 1'b0;
         else if (busy_ff)
            cnt_ff <= cnt_ff - 1'b1;
      end
   end

   assign busy = busy_ff;
   assign done = done_ff;
endmodule : urpsc_timer

`default_nettype wire

// File: urpsc_port.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1 - Reset write one starts reset signalling
// R2 - Reset end clears active, sets done flag
// R3 - Reset on empty port sets connect change
// R4 - Overcurrent bit mirrors input if per-port
// R5 - Resume write starts resume only when suspended
// R6 - Suspend write sets; clears at resume end
// R7 - Reset end or controller resume clears suspend
// R8 - Suspend on empty port sets connect change
// R9 - Faults clear enable, set enable change
// R10 - Enable and disable write-one commands
// R11 - No enable while empty; flag connect change
// R12 - Reset completion sets enabled
// R13 - Connection bit follows attach, not writes
// R14 - Fixed attachment forces connection bit one while powered
// R15 - Connect change sets on events, write-one clears
// R16 - Power off clears connect, enable, suspend and reset bits
// R17 - Internal counter times reset and resume
module urpsc_port
   import urpsc_pkg::*;
#(
   parameter int RESET_CNT  = RESET_CYCLES,
   parameter int RESUME_CNT = RESUME_CYCLES
)
(
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Port side
   input  wire logic        device_attached,
   input  wire logic        overcurrent_in,
   input  wire logic        babble_error,
   input  wire logic        controller_resume_state,
   output logic             port_reset_drive,
   output logic             port_resume_drive,
   // Interrupt
   output logic             irq
);
   function automatic logic wr_one(input logic hit, input logic [31:0] d, input int pos);
      wr_one = hit && d[pos];
   endfunction : wr_one

   urpsc_state_t state_ff;
   urpsc_state_t nxt_state;
   logic         conn_ff;
   logic         enabled_ff;
   logic         suspended_ff;
   logic         reset_act_ff;
   logic         conn_chg_ff;
   logic         en_chg_ff;
   logic         resume_chg_ff;
   logic         reset_chg_ff;
   logic [2:0]   cfg_ff;
   logic [3:0]   irq_stat_ff;
   logic [3:0]   irq_mask_ff;
   logic [31:0]  prdata_ff;
   logic         nxt_enabled;
   logic         nxt_suspended;
   logic         nxt_reset_act;
   logic         tmr_busy;
   logic         tmr_done;

   // Bus decode; zero wait states
   wire access    = psel && penable;
   wire wr        = access && pwrite;
   wire rd_setup  = psel && !penable && !pwrite;
   wire hit_port  = paddr == OFS_PORT_STATUS;
   wire hit_cfg   = paddr == OFS_CONFIG;
   wire hit_istat = paddr == OFS_IRQ_STATUS;
   wire hit_imask = paddr == OFS_IRQ_MASK;
   wire mapped    = hit_port || hit_cfg || hit_istat || hit_imask;
   wire refused   = access && !mapped;
   wire wr_port   = wr && hit_port;

   // Software commands
   wire cmd_disable = wr_one(wr_port, pwdata, BIT_CONNECTED);
   wire cmd_enable  = wr_one(wr_port, pwdata, BIT_ENABLED);
   wire cmd_suspend = wr_one(wr_port, pwdata, BIT_SUSPENDED);
   wire cmd_resume  = wr_one(wr_port, pwdata, BIT_OVERCURRENT);
   wire cmd_reset   = wr_one(wr_port, pwdata, BIT_RESET_ACT);
   wire clr_conn    = wr_one(wr_port, pwdata, BIT_CONN_CHG);
   wire clr_en      = wr_one(wr_port, pwdata, BIT_EN_CHG);
   wire clr_resume  = wr_one(wr_port, pwdata, BIT_RESUME_CHG);
   wire clr_reset   = wr_one(wr_port, pwdata, BIT_RESET_CHG);

   // Port condition
   wire power_on     = cfg_ff[CFG_POWER];
   wire fixed_att    = cfg_ff[CFG_FIXED_ATT];
   wire nxt_conn     = power_on && (device_attached || fixed_att); // [R13] [R14] [R16]
   wire conn_event   = nxt_conn != conn_ff;                        // [R15]
   wire disconnect   = conn_ff && !nxt_conn;
   wire oc_flag      = cfg_ff[CFG_PER_PORT_OC] && overcurrent_in;  // [R4]
   // Any fault drops the enable; the enable change is flagged only if it was on
   wire fault        = overcurrent_in || disconnect || !power_on || babble_error; // [R9]
   // Losing the device cuts signalling short, with no done flag
   wire abort_sig    = !nxt_conn;
   wire reset_done   = (state_ff == URPSC_RESET) && tmr_done;
   wire resume_done  = (state_ff == URPSC_RESUME) && tmr_done;
   // Reset and resume commands are dropped while a sequence runs; reset beats resume
   wire seq_idle     = state_ff == URPSC_IDLE;
   wire reset_start  = cmd_reset && conn_ff && seq_idle;                     // [R1]
   wire resume_start = cmd_resume && suspended_ff && seq_idle
                       && !cmd_reset;                                        // [R5]
   wire empty_cmd    = !conn_ff && (cmd_reset || cmd_enable || cmd_suspend); // [R3] [R8] [R11]
   wire set_conn_chg = conn_event || empty_cmd;
   wire set_en_chg   = enabled_ff && fault;                                  // [R9]

   wire [TMR_W-1:0] tmr_load = reset_start ? TMR_W'(RESET_CNT) : TMR_W'(RESUME_CNT);

   urpsc_timer u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (reset_start || resume_start), // [R17]
      .abort   (abort_sig),
      .load    (tmr_load),
      .busy    (tmr_busy),
      .done    ()
   );
   // Done only on a natural end; an abort leaves no flag
   logic tmr_busy_q_ff;
   wire  tmr_busy_fall = tmr_busy_q_ff && !tmr_busy && !abort_sig;
   assign tmr_done = tmr_busy_fall;

   // Signalling sequencer
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         URPSC_IDLE:
         begin
            if (reset_start)
               nxt_state = URPSC_RESET;
            else if (resume_start)
               nxt_state = URPSC_RESUME;
         end
         URPSC_RESET:
         begin
            if (reset_done || abort_sig)
               nxt_state = URPSC_IDLE;
         end
         URPSC_RESUME:
         begin
            if (resume_done || abort_sig)
               nxt_state = URPSC_IDLE;
         end
         default:
            nxt_state = URPSC_IDLE;
      endcase
   end

   // Enable status
   // Faults win, so a dead port never reads enabled
   always_comb
   begin
      if (fault)
         nxt_enabled = 1'b0;                     // [R9] [R16]
      else if (reset_done)
         nxt_enabled = 1'b1;                     // [R12]
      else if (cmd_disable)
         nxt_enabled = 1'b0;                     // [R10]
      else if (cmd_enable && conn_ff)
         nxt_enabled = 1'b1;                     // [R10] [R11]
      else
         nxt_enabled = enabled_ff;
   end

   // Suspend status
   // Detach drops suspend, since nothing is left to resume
   always_comb
   begin
      if (!nxt_conn)
         nxt_suspended = 1'b0;                   // [R16]
      else if (reset_done || resume_done || controller_resume_state)
         nxt_suspended = 1'b0;                   // [R6] [R7]
      else if (cmd_suspend && conn_ff)
         nxt_suspended = 1'b1;                   // [R6] [R8]
      else
         nxt_suspended = suspended_ff;
   end

   // Reset status
   always_comb
   begin
      if (!nxt_conn || reset_done)
         nxt_reset_act = 1'b0;                   // [R2] [R16]
      else if (reset_start)
         nxt_reset_act = 1'b1;                   // [R1] [R3]
      else
         nxt_reset_act = reset_act_ff;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff      <= URPSC_IDLE;
         conn_ff       <= 1'b0;
         enabled_ff    <= 1'b0;
         suspended_ff  <= 1'b0;
         reset_act_ff  <= 1'b0;
         tmr_busy_q_ff <= 1'b0;
      end
      else
      begin
         state_ff      <= nxt_state;
         conn_ff       <= nxt_conn;
         enabled_ff    <= nxt_enabled;
         suspended_ff  <= nxt_suspended;
         reset_act_ff  <= nxt_reset_act;
         tmr_busy_q_ff <= tmr_busy;
      end
   end

   // Sticky change flags; a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         conn_chg_ff   <= 1'b0;
         en_chg_ff     <= 1'b0;
         resume_chg_ff <= 1'b0;
         reset_chg_ff  <= 1'b0;
      end
      else
      begin
         conn_chg_ff   <= set_conn_chg || (conn_chg_ff && !clr_conn);  // [R15] [R3]
         en_chg_ff     <= set_en_chg || (en_chg_ff && !clr_en);        // [R9]
         resume_chg_ff <= resume_done || (resume_chg_ff && !clr_resume); // [R6]
         reset_chg_ff  <= reset_done || (reset_chg_ff && !clr_reset);  // [R2]
      end
   end

   // Interrupt status follows change events, write one to clear
   wire       wr_cfg   = wr && hit_cfg;
   wire       wr_istat = wr && hit_istat;
   wire       wr_imask = wr && hit_imask;
   wire [3:0] irq_set  = {reset_done, resume_done, set_en_chg, set_conn_chg};
   wire [3:0] irq_clr  = wr_istat ? pwdata[3:0] : 4'h0;

   // Set wins over a same-cycle clear, so no event is lost
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat_ff <= 4'h0;
      else
         irq_stat_ff <= irq_set | (irq_stat_ff & ~irq_clr);
   end

   // Power resets on, so an attached device is seen at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_ff <= CFG_RESET;
      else if (wr_cfg)
         cfg_ff <= pwdata[2:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask_ff <= IRQ_MASK_RESET;
      else if (wr_imask)
         irq_mask_ff <= pwdata[3:0];
   end

   // Read data; the overcurrent bit is sampled live
   wire [31:0] port_word = {11'h000, reset_chg_ff, 1'b0, resume_chg_ff, en_chg_ff,
                            conn_chg_ff, 11'h000, reset_act_ff, oc_flag,
                            suspended_ff, enabled_ff, conn_ff};
   wire [31:0] rd_mux = hit_port  ? port_word :
                        hit_cfg   ? {29'h0, cfg_ff} :
                        hit_istat ? {28'h0, irq_stat_ff} :
                        hit_imask ? {28'h0, irq_mask_ff} : 32'h0000_0000;

   // Captured in setup so the word stands through the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_ff <= 32'h0000_0000;
      else if (rd_setup)
         prdata_ff <= rd_mux;
   end

   assign prdata            = prdata_ff;
   assign pready            = 1'b1;
   assign pslverr           = refused;
   assign irq               = |(irq_stat_ff & irq_mask_ff);
   assign port_reset_drive  = reset_act_ff;                         // [R1]
   assign port_resume_drive = state_ff == URPSC_RESUME;
endmodule : urpsc_port

`default_nettype wire

// File: urpsc_dev_model.sv
`timescale 1ns/100ps
`default_nettype none

module urpsc_dev_model
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Bench requests
   input  wire logic plug,
   input  wire logic fault_oc,
   input  wire logic fault_babble,
   // Port lines
   input  wire logic port_reset_drive,
   output logic      device_attached,
   output logic      overcurrent_in,
   output logic      babble_error
);
   // A device held in reset cannot babble, so the error is masked
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         device_attached <= 1'h0;
         overcurrent_in  <= 1'h0;
         babble_error    <= 1'h0;
      end
      else
      begin
         device_attached <= plug;
         overcurrent_in  <= fault_oc;
         babble_error    <= fault_babble && !port_reset_drive;
      end
   end
endmodule : urpsc_dev_model

`default_nettype wire

// File: urpsc_port_chk.sv
`timescale 1ns/100ps
`default_nettype none

module urpsc_port_chk
   import urpsc_pkg::*;
#(
   parameter int RESET_CNT  = RESET_CYCLES,
   parameter int RESUME_CNT = RESUME_CYCLES
)
(
   // APB
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Port side
   input wire logic        device_attached,
   input wire logic        overcurrent_in,
   input wire logic        babble_error,
   input wire logic        controller_resume_state,
   input wire logic        port_reset_drive,
   input wire logic        port_resume_drive,
   input wire logic        irq
);
   logic [19:0] rst_cnt_ff;
   logic [19:0] rsm_cnt_ff;
   wire logic   acc    = psel && penable;
   wire logic   mapped = paddr inside {OFS_PORT_STATUS, OFS_CONFIG, OFS_IRQ_STATUS, OFS_IRQ_MASK};
   wire logic   wr_st  = acc && pwrite && (paddr == OFS_PORT_STATUS);
   wire logic   rst_rq = wr_st && pwdata[BIT_RESET_ACT];
   wire logic   rsm_rq = wr_st && pwdata[BIT_OVERCURRENT];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_cnt_ff <= '0;
         rsm_cnt_ff <= '0;
      end
      else
      begin
         rst_cnt_ff <= port_reset_drive ? rst_cnt_ff + 20'h1 : '0;
         rsm_cnt_ff <= port_resume_drive ? rsm_cnt_ff + 20'h1 : '0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence idle_attached;
      device_attached && $past(device_attached) && !port_reset_drive && !port_resume_drive;
   endsequence
   sequence reset_starts;
      ##[1:2] port_reset_drive;
   endsequence

   chk_ready_always: assert property (pready) else $error("pready low");
   chk_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
   chk_mapped_ok: assert property (!(acc && !mapped) |-> !pslverr) else $error("bad pslverr");
   chk_reset_start: assert property (rst_rq and idle_attached |-> reset_starts)
      else $error("reset not started");
   chk_reset_cause: assert property ($rose(port_reset_drive) |->
      ($past(rst_rq) || $past(rst_rq, 2)) && $past(device_attached, 2))
      else $error("reset without command");
   chk_reset_len: assert property ($fell(port_reset_drive) |->
      rst_cnt_ff inside {[RESET_CNT:RESET_CNT+1]}) else $error("reset length");
   chk_resume_len: assert property ($fell(port_resume_drive) |->
      rsm_cnt_ff inside {[RESUME_CNT:RESUME_CNT+1]}) else $error("resume length");
   chk_resume_cause: assert property ($rose(port_resume_drive) |->
      $past(rsm_rq) || $past(rsm_rq, 2)) else $error("resume without command");
   chk_drives_apart: assert property (!(port_reset_drive && port_resume_drive))
      else $error("both drives high");
   chk_quiet_release: assert property ($rose(presetn) |-> !irq && !port_reset_drive)
      else $error("busy after reset");
endmodule : urpsc_port_chk

bind urpsc_port urpsc_port_chk #(.RESET_CNT(RESET_CNT), .RESUME_CNT(RESUME_CNT))
   urpsc_port_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .device_attached(device_attached), .overcurrent_in(overcurrent_in),
   .babble_error(babble_error), .controller_resume_state(controller_resume_state),
   .port_reset_drive(port_reset_drive), .port_resume_drive(port_resume_drive), .irq(irq));

`default_nettype wire

// File: urpsc_port_bench.sv
`timescale 1ns/100ps
`default_nettype none

module urpsc_port_bench
   import urpsc_pkg::*;
;
   localparam logic [31:0] M = 32'h0015_001F;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic        device_attached, overcurrent_in, babble_error, controller_resume_state;
   logic        port_reset_drive, port_resume_drive, plug, fault_oc, fault_babble;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          n_errors, n_tests, cyc;

   urpsc_port #(.RESET_CNT(8), .RESUME_CNT(12)) urpsc_port_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .device_attached(device_attached), .overcurrent_in(overcurrent_in),
      .babble_error(babble_error), .controller_resume_state(controller_resume_state),
      .port_reset_drive(port_reset_drive), .port_resume_drive(port_resume_drive), .irq(irq));
   urpsc_dev_model urpsc_dev_model_inst (.pclk(pclk), .presetn(presetn), .plug(plug),
      .fault_oc(fault_oc), .fault_babble(fault_babble), .port_reset_drive(port_reset_drive),
      .device_attached(device_attached), .overcurrent_in(overcurrent_in),
      .babble_error(babble_error));

   always #20 pclk = ~pclk;

   function automatic logic [31:0] st(input logic [4:0] lo, input logic [3:0] fl);
      return {11'h0, fl[3], 1'h0, fl[2:0], 11'h0, lo};
   endfunction : st

   task automatic test_done();
      if (n_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex)
      begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
      apb(1'h0, a, 32'h0);
      chk("register", ex & m, rd & m);
   endtask : rdchk

   task automatic settle();
      repeat (3) @(posedge pclk);
      while (port_reset_drive !== 1'h0 || port_resume_drive !== 1'h0) @(posedge pclk);
      @(posedge pclk);
   endtask : settle

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         n_errors++;
         test_done();
      end
   end

   initial
   begin
      {pclk, presetn, psel, penable, pwrite, plug, fault_oc, fault_babble} = '0;
      {controller_resume_state, paddr, pwdata} = '0;
      void'($urandom(32'h3380_1394));
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      rdchk(OFS_PORT_STATUS, 32'h0017_001F, 32'h0);
      rdchk(OFS_CONFIG, 32'h7, {29'h0, CFG_RESET});
      chk("irq", 32'h0, {31'h0, irq});
      for (int b = 1; b < 5; b = b * 2)
      begin
         apb(1'h1, OFS_PORT_STATUS, 32'h1 << b);
         rdchk(OFS_PORT_STATUS, M, st(5'h00, 4'h1));
         apb(1'h1, OFS_PORT_STATUS, 32'h0001_0000);
         rdchk(OFS_PORT_STATUS, M, 32'h0);
      end
      apb(1'h1, OFS_IRQ_STATUS, 32'hF);
      apb(1'h1, OFS_IRQ_MASK, 32'hF);
      chk("irq", 32'h0, {31'h0, irq});
      plug <= 1'h1;
      repeat (3) @(posedge pclk);
      chk("irq", 32'h1, {31'h0, irq});
      rdchk(OFS_PORT_STATUS, M, st(5'h01, 4'h1));
      apb(1'h1, OFS_PORT_STATUS, 32'h0001_0001);
      apb(1'h1, OFS_IRQ_STATUS, 32'hF);
      chk("irq", 32'h0, {31'h0, irq});
      rdchk(OFS_PORT_STATUS, M, st(5'h01, 4'h0));
      apb(1'h1, OFS_PORT_STATUS, 32'h2);
      rdchk(OFS_PORT_STATUS, M, st(5'h03, 4'h0));
      apb(1'h1, OFS_PORT_STATUS, 32'h1);
      rdchk(OFS_PORT_STATUS, M, st(5'h01, 4'h0));
      apb(1'h1, OFS_PORT_STATUS, 32'h10);
      rdchk(OFS_PORT_STATUS, M, st(5'h11, 4'h0));
      settle();
      rdchk(OFS_PORT_STATUS, M, st(5'h03, 4'h8));
      apb(1'h1, OFS_PORT_STATUS, 32'h0017_0004);
      apb(1'h1, OFS_PORT_STATUS, 32'h8);
      rdchk(OFS_PORT_STATUS, M, st(5'h07, 4'h0));
      settle();
      rdchk(OFS_PORT_STATUS, M, st(5'h03, 4'h4));
      apb(1'h1, OFS_PORT_STATUS, 32'h0017_0008);
      chk("resume drive", 32'h0, {31'h0, port_resume_drive});
      apb(1'h1, OFS_PORT_STATUS, 32'h4);
      apb(1'h1, OFS_PORT_STATUS, 32'h10);
      settle();
      rdchk(OFS_PORT_STATUS, M, st(5'h03, 4'h8));
      apb(1'h1, OFS_PORT_STATUS, 32'h0017_0004);
      controller_resume_state <= 1'h1;
      @(posedge pclk);
      controller_resume_state <= 1'h0;
      rdchk(OFS_PORT_STATUS, 32'h7, 32'h3);
      repeat (8)
      begin
         apb(1'h1, OFS_PORT_STATUS, $urandom & 32'hFFE8_FFE0);
         rdchk(OFS_PORT_STATUS, M, st(5'h03, 4'h0));
         apb(1'h1, 8'($urandom_range(4, 63) << 2), $urandom);
         apb(1'h0, 8'($urandom_range(4, 63) << 2), 32'h0);
         chk("refused error", 32'h1, {31'h0, er});
         chk("refused data", 32'h0, rd);
      end
      rdchk(OFS_CONFIG, 32'h7, 32'h4);
      apb(1'h1, OFS_CONFIG, 32'h5);
      fault_oc <= 1'h1;
      repeat (3) @(posedge pclk);
      rdchk(OFS_PORT_STATUS, 32'h0002_000B, st(5'h09, 4'h2));
      apb(1'h1, OFS_CONFIG, 32'h4);
      rdchk(OFS_PORT_STATUS, 32'h8, 32'h0);
      fault_oc <= 1'h0;
      apb(1'h1, OFS_IRQ_MASK, 32'h0);
      apb(1'h1, OFS_PORT_STATUS, 32'h0017_0002);
      apb(1'h1, OFS_IRQ_STATUS, 32'hF);
      fault_babble <= 1'h1;
      @(posedge pclk);
      fault_babble <= 1'h0;
      repeat (3) @(posedge pclk);
      rdchk(OFS_PORT_STATUS, 32'h0002_0002, st(5'h00, 4'h2));
      chk("irq", 32'h0, {31'h0, irq});
      rdchk(OFS_IRQ_STATUS, 32'hF, 32'h2);
      apb(1'h1, OFS_IRQ_MASK, 32'h2);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'h1, OFS_IRQ_STATUS, 32'h2);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'h1, OFS_PORT_STATUS, 32'h0017_0002);
      plug <= 1'h0;
      repeat (3) @(posedge pclk);
      rdchk(OFS_PORT_STATUS, 32'h0003_0003, st(5'h00, 4'h3));
      apb(1'h1, OFS_CONFIG, 32'h6);
      rdchk(OFS_PORT_STATUS, 32'h1, 32'h1);
      apb(1'h1, OFS_CONFIG, 32'h2);
      rdchk(OFS_PORT_STATUS, 32'h1F, 32'h0);
      test_done();
   end
endmodule : urpsc_port_bench

`default_nettype wire
